// File: rtl/spm_defs.svh
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH

// Register space decoded by this block (byte addresses)
`define SPM_IOP_LO          32'h0000_0000
`define SPM_IOP_HI          32'h0003_ffff
`define SPM_SYSCFG_ADDR     32'h0000_0000
`define SPM_PWRCLK_ADDR     32'h0000_0004

// System config fields
`define SPM_SYSCFG_RESET    32'h0000_0000
`define SPM_SYSCFG_WMASK    32'h3fdf_ffff
`define SPM_B_IRQ0          16
`define SPM_B_IRQ1          17
`define SPM_B_IRQ2          18
`define SPM_B_TIMER_EXPIRED_OUT        19
`define SPM_B_PPMUX         20
`define SPM_B_FLGA          22
`define SPM_B_FLGB          23
`define SPM_B_FLGC          24
`define SPM_B_FLGD          25
`define SPM_B_PWMA          26
`define SPM_B_PWMB          27
`define SPM_B_PWMC          28
`define SPM_B_PWMD          29

// Power/clock control fields
`define SPM_B_DIVLOAD       9
`define SPM_B_BYPASS        15
`define SPM_PWRCLK_RESET    32'h0000_0000
`define SPM_F_DIV_LO        6
`define SPM_B_INDIV         8
`define SPM_F_RATIO_LO      16
`define SPM_F_SHDN_LO       26
`define SPM_PWRCLK_WMASK    32'hfc00_81ff
`define SPM_MULT_CFG00      6'h00
`define SPM_MULT_CFG01      6'h20
`define SPM_MULT_CFG10      6'h10
`define SPM_MULT_CFG11      6'h06

`endif

// File: rtl/spm_group_mux.sv
`timescale 1ns/1ps
// Steers one 4-pin address/data group to parallel port, flags or pulse outputs
module spm_group_mux (
  input  wire logic [1:0] mode_i,      // spm_pkg::spm_grp_e code
  input  wire logic [3:0] pp_o_i,      // Parallel port out data
  input  wire logic [3:0] pp_oe_i,     // Parallel port out enable
  input  wire logic [3:0] flag_o_i,    // Flag out data
  input  wire logic [3:0] flag_oe_i,   // Flag out enable
  input  wire logic [3:0] pwm_i,       // Pulse outputs
  output logic      [3:0] pin_o,       // Pin out
  output logic      [3:0] pin_oe_o     // Pin drive enable
);
  // Select source
  always_comb
  begin
    case (mode_i)
      spm_pkg::SPM_FLAG:
      begin
        pin_o    = flag_o_i;
        pin_oe_o = flag_oe_i;
      end
      spm_pkg::SPM_PWM:
      begin
        pin_o    = pwm_i;
        pin_oe_o = 4'hf;
      end
      default:
      begin
        pin_o    = pp_o_i;
        pin_oe_o = pp_oe_i;
      end
    endcase
  end
endmodule : spm_group_mux

// File: rtl/spm_pkg.sv
package spm_pkg;
  // Function of one group of four address/data pins
  typedef enum logic [1:0] {
    SPM_PP   = 2'b00,
    SPM_FLAG = 2'b01,
    SPM_PWM  = 2'b10
  } spm_grp_e;
endpackage : spm_pkg

// File: rtl/spm_top.sv
`timescale 1ns/1ps
`include "spm_defs.svh"
// Functional notes
// R1: System config clears to zero on reset
// R2: Bit16 selects flag0 GPIO or IRQ0 input
// R3: Bit17 selects flag1 GPIO or IRQ1 input
// R4: Bit18 selects flag2 GPIO or IRQ2 input
// R5: Bit19 selects flag3 GPIO or timer output
// R6: Bit20 disables port mux, enabling flag mode; here the pin group muxes ignore bit20, only bits 22-29 steer them
// R7: Pins as flags force flag0-3 alternate roles
// R8: Bit22 routes pins 11-8 as flags 3-0
// R9: Bit23 routes pins 15-12 as flags 7-4
// R10: Bit24 routes pins 3-0 as flags 11-8
// R11: Bit25 routes pins 7-4 as flags 15-12
// R12: Bit26 puts pins 11-8 in pulse mode
// R13: Bit27 puts pins 15-12 in pulse mode
// R14: Bit28 puts pins 3-0 in pulse mode
// R15: Bit29 puts pins 7-4 in pulse mode
// R16: Software writes zero to reserved bits
// R17: Registers decoded within I/O processor space
// R18: Power/clock low bits reset from strap pins
// R19: Ratio status bits ignore core writes
// R20: Divider load is one-shot, reads zero
// R21: Software separates divider load and bypass writes
// R22: Divider load transfers divider field to PLL
// R23: Updates take effect next clock edge
module spm_top (
  input  wire logic        CLK_I,               // Core clock
  input  wire logic        RSTN_I,              // Sync reset, active low
  input  wire logic [1:0]  CLK_CFG_I,           // Clock ratio strap pins
  input  wire logic        REG_WR_I,            // Core register write strobe
  input  wire logic        REG_RD_I,            // Core register read strobe
  input  wire logic [31:0] REG_ADDR_I,          // Core register address
  input  wire logic [31:0] REG_WDATA_I,         // Core write data
  output logic      [31:0] REG_RDATA_O,         // Core read data
  input  wire logic [3:0]  FLAG_PIN_I,          // Dedicated flag pins in
  output logic      [3:0]  FLAG_PIN_O,          // Dedicated flag pins out
  output logic      [3:0]  FLAG_PIN_OE_O,       // Dedicated flag pins drive enable
  input  wire logic [3:0]  GPIO_OUT_I,          // Core flag output values
  input  wire logic [3:0]  GPIO_DIR_I,          // Core flag directions, 1 = out
  output logic      [15:0] FLAG_IN_O,           // Flag input values to core
  input  wire logic [15:0] PPFLAG_OUT_I,        // Core values for pin flags 15-0
  input  wire logic [15:0] PPFLAG_DIR_I,        // Pin flag directions, 1 = out
  input  wire logic        TIMER_EXPIRED_I,     // Core timer expired
  output logic [2:0]       IRQ_O,               // Interrupt request lines
  input  wire logic [15:0] PP_OUT_I,            // Parallel port data out
  input  wire logic [15:0] PP_OE_I,             // Parallel port drive enables
  output logic [15:0]      PP_IN_O,             // Parallel port data in
  input  wire logic [15:0] PWM_I,               // Pulse generator outputs
  input  wire logic [15:0] PPORT_ADDR_DATA_PINS_I,  // Address/data pins in
  output logic      [15:0] PPORT_ADDR_DATA_PINS_O,  // Address/data pins out
  output logic      [15:0] PPORT_ADDR_DATA_PINS_OE_O, // Address/data pins enable
  output logic      [5:0]  PLL_MULT_O,          // PLL multiplier
  output logic      [1:0]  PLL_DIV_O,           // Loaded PLL output divider
  output logic             PLL_INDIV_O,         // PLL input divisor
  output logic             PLL_BYPASS_O,        // PLL bypass
  output logic      [5:0]  CLK_SHUTDOWN_O       // Peripheral clock shutdowns
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  // System config register
  logic [31:0] system_config;
  logic [31:0] next_system_config;

  // Power/clock control register and the divider the PLL really uses
  logic [31:0] power_clock_control;
  logic [31:0] next_power_clock_control;
  logic [1:0]  pll_div;
  logic [1:0]  next_pll_div;

  // Clock ratio strap capture, done once per reset release
  logic [1:0]  clk_ratio;
  logic [1:0]  next_clk_ratio;
  logic        strap_done;
  logic        next_strap_done;

  // Register selects and pin steering
  logic        sel_sys;
  logic        sel_pwr;
  logic        pins_as_flags;

  // Address decode within the I/O processor space; anything outside it
  // or at an unused offset selects nothing and reads back zero
  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a <= `SPM_IOP_HI) && (a == r);
  endfunction : hit

  // Strap code to multiplier; the reserved code still gets a defined value
  function automatic logic [5:0] strap_mult(input logic [1:0] c);
    case (c)
      2'b00:   strap_mult = `SPM_MULT_CFG00;
      2'b01:   strap_mult = `SPM_MULT_CFG01;
      2'b10:   strap_mult = `SPM_MULT_CFG10;
      default: strap_mult = `SPM_MULT_CFG11;
    endcase
  endfunction : strap_mult

  // Function of one pin group; its flag select wins over its pulse select
  function automatic logic [1:0] grp_decode(input logic flag_sel, input logic pulse_sel);
    if (flag_sel)
      grp_decode = spm_pkg::SPM_FLAG;
    else if (pulse_sel)
      grp_decode = spm_pkg::SPM_PWM;
    else
      grp_decode = spm_pkg::SPM_PP;
  endfunction : grp_decode

  // First flag number carried by pin group g (pins 4g+3 down to 4g)
  function automatic logic [3:0] flag_base(input logic [1:0] g);
    case (g)
      2'h0:    flag_base = 4'h8;   // Pins 3-0 carry flags 11-8
      2'h1:    flag_base = 4'hc;   // Pins 7-4 carry flags 15-12
      2'h2:    flag_base = 4'h0;   // Pins 11-8 carry flags 3-0
      default: flag_base = 4'h4;   // Pins 15-12 carry flags 7-4
    endcase
  endfunction : flag_base

  // Register selects
  assign sel_sys = hit(REG_ADDR_I, `SPM_SYSCFG_ADDR);   // see R17
  assign sel_pwr = hit(REG_ADDR_I, `SPM_PWRCLK_ADDR);   // see R17

  ////////////////////////////////////////////////////////////////////////////
  // System config next value; reserved bits always land as zero
  always_comb
  begin
    // Default holds the register
    next_system_config = system_config;
    if (REG_WR_I && sel_sys)
      next_system_config = REG_WDATA_I & `SPM_SYSCFG_WMASK;  // see R16, R23
  end

  // System config register
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      system_config <= `SPM_SYSCFG_RESET;                     // see R1
    else
      system_config <= next_system_config;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power/clock next values; a write in the strap cycle is lost to the capture
  always_comb
  begin
    // Defaults hold every register except strap_done, which sets
    next_power_clock_control = power_clock_control;
    next_pll_div             = pll_div;
    next_clk_ratio           = clk_ratio;
    next_strap_done          = 1'b1;
    if (!strap_done)
    begin
      // First clock after reset release captures straps
      next_power_clock_control[5:0] = strap_mult(CLK_CFG_I);  // see R18
      next_clk_ratio                = CLK_CFG_I;
    end
    else if (REG_WR_I && sel_pwr)
    begin
      // Ratio bits are not in the write mask
      next_power_clock_control = REG_WDATA_I & `SPM_PWRCLK_WMASK;  // see R19
      // Load command is never stored, so it cannot fire twice
      next_power_clock_control[`SPM_B_DIVLOAD] = 1'b0;             // see R20
      if (REG_WDATA_I[`SPM_B_DIVLOAD])
        next_pll_div = REG_WDATA_I[`SPM_F_DIV_LO +: 2];            // see R22
    end
  end

  // Power/clock register, loaded divider and strap capture
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      power_clock_control <= `SPM_PWRCLK_RESET;
      pll_div             <= 2'h0;
      clk_ratio           <= 2'h0;
      strap_done          <= 1'b0;
    end
    else
    begin
      power_clock_control <= next_power_clock_control;
      pll_div             <= next_pll_div;
      clk_ratio           <= next_clk_ratio;
      strap_done          <= next_strap_done;
    end
  end

  // Read data; the divider load bit always reads zero
  always_comb
  begin
    REG_RDATA_O = 32'h0000_0000;
    if (REG_RD_I && sel_sys)
      REG_RDATA_O = system_config;
    else if (REG_RD_I && sel_pwr)
    begin
      REG_RDATA_O                       = power_clock_control;
      // Load command is not kept, and the ratio field mirrors the straps
      REG_RDATA_O[`SPM_B_DIVLOAD]       = 1'b0;       // see R20
      REG_RDATA_O[`SPM_F_RATIO_LO +: 2] = clk_ratio;  // see R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL controls straight from the register
  assign PLL_MULT_O     = power_clock_control[5:0];
  assign PLL_INDIV_O    = power_clock_control[`SPM_B_INDIV];
  assign PLL_BYPASS_O   = power_clock_control[`SPM_B_BYPASS];

  // Output divider changes only on an explicit load command
  assign PLL_DIV_O      = pll_div;                              // see R22

  // Peripheral clock shutdown bits
  assign CLK_SHUTDOWN_O = power_clock_control[`SPM_F_SHDN_LO +: 6];

  ////////////////////////////////////////////////////////////////////////////
  // Dedicated flag pins
  assign pins_as_flags = system_config[`SPM_B_PPMUX];  // see R6

  // Flag pins 0-2 to IRQ or GPIO, flag 3 to timer or GPIO.
  // A pin used as an interrupt input must not be driven, so its enable drops;
  // pins-as-flags mode forces all four alternate roles at once.
  always_comb
  begin
    FLAG_PIN_O    = GPIO_OUT_I;
    FLAG_PIN_OE_O = GPIO_DIR_I;
    IRQ_O         = 3'h0;
    for (int i = 0; i < 3; i++)
    begin
      if (system_config[`SPM_B_IRQ0 + i] || pins_as_flags)  // see R2, R3, R4, R7
      begin
        FLAG_PIN_OE_O[i] = 1'b0;
        IRQ_O[i]         = FLAG_PIN_I[i];
      end
    end
    if (system_config[`SPM_B_TIMER_EXPIRED_OUT] || pins_as_flags)     // see R5, R7
    begin
      FLAG_PIN_O[3]    = TIMER_EXPIRED_I;
      FLAG_PIN_OE_O[3] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address/data pin groups, pins [4g+3:4g], flag slot from mapping
  logic [1:0] grp_mode [4];   // Function of each pin group
  logic [3:0] grp_flag [4];   // Flag index base per pin group

  // Group g of pins: 0=AD3-0, 1=AD7-4, 2=AD11-8, 3=AD15-12
  always_comb
  begin
    for (int g = 0; g < 4; g++)
      grp_flag[g] = flag_base(2'(g));
    // Pins 3-0
    grp_mode[0] = grp_decode(system_config[`SPM_B_FLGC],    // see R10
                             system_config[`SPM_B_PWMC]);   // see R14
    // Pins 7-4
    grp_mode[1] = grp_decode(system_config[`SPM_B_FLGD],    // see R11
                             system_config[`SPM_B_PWMD]);   // see R15
    // Pins 11-8
    grp_mode[2] = grp_decode(system_config[`SPM_B_FLGA],    // see R8
                             system_config[`SPM_B_PWMA]);   // see R12
    // Pins 15-12
    grp_mode[3] = grp_decode(system_config[`SPM_B_FLGB],    // see R9
                             system_config[`SPM_B_PWMB]);   // see R13
  end

  // Flag inputs gathered from pins in flag mode; dedicated pins read as
  // flags 3-0 unless pins-as-flags mode is on, and a pin group
  // in flag mode takes over its four flag slots
  always_comb
  begin
    FLAG_IN_O = 16'h0000;
    FLAG_IN_O[3:0] = pins_as_flags ? 4'h0 : FLAG_PIN_I;
    for (int g = 0; g < 4; g++)
    begin
      if (grp_mode[g] == 2'b01)
        FLAG_IN_O[grp_flag[g] +: 4] = PPORT_ADDR_DATA_PINS_I[4*g +: 4];
    end
  end

  // Parallel port always sees the raw pins
  assign PP_IN_O = PPORT_ADDR_DATA_PINS_I;

  // One mux per group; an undriven pin group leaves its enables low
  // unless the parallel port, the flag directions or pulse mode ask for drive
  genvar gv;
  generate
    for (gv = 0; gv < 4; gv++)
    begin : g_grp
      spm_group_mux u_mux (
        .mode_i    (grp_mode[gv]),
        .pp_o_i    (PP_OUT_I[4*gv +: 4]),
        .pp_oe_i   (PP_OE_I[4*gv +: 4]),
        .flag_o_i  (PPFLAG_OUT_I[grp_flag[gv] +: 4]),
        .flag_oe_i (PPFLAG_DIR_I[grp_flag[gv] +: 4]),
        .pwm_i     (PWM_I[4*gv +: 4]),
        .pin_o     (PPORT_ADDR_DATA_PINS_O[4*gv +: 4]),
        .pin_oe_o  (PPORT_ADDR_DATA_PINS_OE_O[4*gv +: 4])
      );
    end
  endgenerate

endmodule : spm_top

// File: tb/spm_chk.sv
`timescale 1ns/1ps
`include "spm_defs.svh"
// Port checks on register access and clock control outputs
module spm_chk (
  input wire logic        CLK_I,          // Core clock
  input wire logic        RSTN_I,         // Sync reset
  input wire logic [1:0]  CLK_CFG_I,      // Strap pins
  input wire logic        REG_WR_I,       // Write strobe
  input wire logic        REG_RD_I,       // Read strobe
  input wire logic [31:0] REG_ADDR_I,     // Address
  input wire logic [31:0] REG_WDATA_I,    // Write data
  input wire logic [31:0] REG_RDATA_O,    // Read data
  input wire logic [5:0]  PLL_MULT_O,     // Multiplier
  input wire logic [1:0]  PLL_DIV_O,      // Loaded divider
  input wire logic        PLL_BYPASS_O,   // Bypass
  input wire logic [5:0]  CLK_SHUTDOWN_O  // Clock shutdowns
);
  logic pw;
  logic pr;
  logic sr;
  // Access decode
  assign pw = REG_WR_I && (REG_ADDR_I == `SPM_PWRCLK_ADDR);
  assign pr = REG_RD_I && (REG_ADDR_I == `SPM_PWRCLK_ADDR);
  assign sr = REG_RD_I && (REG_ADDR_I == `SPM_SYSCFG_ADDR);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  ////////////////////////////////////////
  a_reset_clear: assert property (disable iff (1'b0) !RSTN_I |=> !PLL_BYPASS_O &&
    CLK_SHUTDOWN_O == 6'h00 && PLL_DIV_O == 2'h0) else $error("reset values wrong");
  a_div_load: assert property (pw && REG_WDATA_I[9] |=>
    PLL_DIV_O == $past(REG_WDATA_I[7:6])) else $error("divider not loaded");
  a_div_hold: assert property (pw && !REG_WDATA_I[9] |=> $stable(PLL_DIV_O))
    else $error("divider changed without load");
  a_load_rdzero: assert property (pr |-> !REG_RDATA_O[9])
    else $error("load bit read nonzero");
  a_status_ro: assert property (pr |-> REG_RDATA_O[17:16] == CLK_CFG_I)
    else $error("ratio status wrong");
  a_unmapped_rd: assert property (REG_RD_I && !pr && !sr |-> REG_RDATA_O == 32'h0)
    else $error("unmapped read nonzero");
  a_sys_resv: assert property (sr |-> (REG_RDATA_O & ~`SPM_SYSCFG_WMASK) == 32'h0)
    else $error("reserved bits read nonzero");
  a_bypass_wr: assert property (pw |=> PLL_BYPASS_O == $past(REG_WDATA_I[15]))
    else $error("bypass not updated");
  a_field_wr: assert property (pw |=> PLL_MULT_O == $past(REG_WDATA_I[5:0]) &&
    CLK_SHUTDOWN_O == $past(REG_WDATA_I[31:26])) else $error("writable field lost");
endmodule : spm_chk

bind spm_top spm_chk u_spm_chk (.CLK_I, .RSTN_I, .CLK_CFG_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I,
  .REG_WDATA_I, .REG_RDATA_O, .PLL_MULT_O, .PLL_DIV_O, .PLL_BYPASS_O, .CLK_SHUTDOWN_O);

// File: tb/spm_top_tb.sv
`timescale 1ns/1ps
module spm_top_tb;
  logic        CLK_I, RSTN_I, REG_WR_I, REG_RD_I, TIMER_EXPIRED_I, PLL_INDIV_O, PLL_BYPASS_O;
  logic [1:0]  CLK_CFG_I, PLL_DIV_O;
  logic [2:0]  IRQ_O;
  logic [3:0]  FLAG_PIN_I, FLAG_PIN_O, FLAG_PIN_OE_O, GPIO_OUT_I, GPIO_DIR_I;
  logic [5:0]  PLL_MULT_O, CLK_SHUTDOWN_O;
  logic [15:0] FLAG_IN_O, PPFLAG_OUT_I, PPFLAG_DIR_I, PP_OUT_I, PP_OE_I, PP_IN_O, PWM_I;
  logic [15:0] PPORT_ADDR_DATA_PINS_I, PPORT_ADDR_DATA_PINS_O, PPORT_ADDR_DATA_PINS_OE_O;
  logic [31:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O;
  logic [15:0] eo, eoe;
  int          errors = 0;
  int          check_count = 0;
  int          pb;
  // Device under test
  spm_top u_spm_top (.CLK_I, .RSTN_I, .CLK_CFG_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I,
    .REG_WDATA_I, .REG_RDATA_O, .FLAG_PIN_I, .FLAG_PIN_O, .FLAG_PIN_OE_O, .GPIO_OUT_I,
    .GPIO_DIR_I, .FLAG_IN_O, .PPFLAG_OUT_I, .PPFLAG_DIR_I, .TIMER_EXPIRED_I, .IRQ_O,
    .PP_OUT_I, .PP_OE_I, .PP_IN_O, .PWM_I, .PPORT_ADDR_DATA_PINS_I, .PPORT_ADDR_DATA_PINS_O,
    .PPORT_ADDR_DATA_PINS_OE_O, .PLL_MULT_O, .PLL_DIV_O, .PLL_INDIV_O, .PLL_BYPASS_O,
    .CLK_SHUTDOWN_O);
  ////////////////////////////////////////
  // Clock
  always #2.5 CLK_I = ~CLK_I;
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : cmp
  // One access cycle, strobes set at the falling edge
  task automatic acc(input logic w, input logic r, input logic [31:0] a, input logic [31:0] d);
    @(negedge CLK_I);
    REG_WR_I = w;
    REG_RD_I = r;
    REG_ADDR_I = a;
    REG_WDATA_I = d;
    #1;
  endtask : acc
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    acc(1'b0, 1'b1, a, 32'h0);
    cmp("rdata", exp, REG_RDATA_O);
  endtask : rd
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // Hang guard
  initial
  begin
    #100000;
    errors++;
    test_done();
  end
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    CLK_I = 1'b0;
    RSTN_I = 1'b0;
    CLK_CFG_I = 2'b01;
    REG_WR_I = 1'b0;
    REG_RD_I = 1'b0;
    REG_ADDR_I = 32'h0;
    REG_WDATA_I = 32'h0;
    FLAG_PIN_I = 4'h6;
    GPIO_OUT_I = 4'ha;
    GPIO_DIR_I = 4'h5;
    PPFLAG_OUT_I = 16'h1234;
    PPFLAG_DIR_I = 16'hf0f0;
    TIMER_EXPIRED_I = 1'b0;
    PP_OUT_I = 16'h5a5a;
    PP_OE_I = 16'h0ff0;
    PWM_I = 16'hc3a5;
    PPORT_ADDR_DATA_PINS_I = 16'h9876;
    repeat (4) @(negedge CLK_I);
    RSTN_I = 1'b1;
    acc(1'b0, 1'b0, 32'h0, 32'h0);
    rd(32'h0, 32'h0);
    rd(32'h4, 32'h0001_0020);
    acc(1'b1, 1'b0, 32'h4, 32'h8402_0385);
    rd(32'h4, 32'h8401_0185);
    cmp("div", 32'h2, PLL_DIV_O);
    cmp("indiv", 32'h1, PLL_INDIV_O);
    acc(1'b1, 1'b0, 32'h4, 32'h0000_00c5);
    rd(32'h4, 32'h0001_00c5);
    cmp("div", 32'h2, PLL_DIV_O);
    cmp("indiv", 32'h0, PLL_INDIV_O);
    acc(1'b1, 1'b0, 32'h4, 32'h0000_8000);
    acc(1'b1, 1'b0, 32'h8, 32'hffff_ffff);
    rd(32'h8, 32'h0);
    rd(32'h4, 32'h0001_8000);
    cmp("bypass", 32'h1, PLL_BYPASS_O);
    acc(1'b1, 1'b0, 32'h0, 32'h3fdf_ffff);
    rd(32'h0, 32'h3fdf_ffff);
    @(negedge CLK_I);
    RSTN_I = 1'b0;
    @(negedge CLK_I);
    RSTN_I = 1'b1;
    acc(1'b0, 1'b0, 32'h0, 32'h0);
    rd(32'h0, 32'h0);
    rd(32'h4, 32'h0001_0020);
    cmp("bypass", 32'h0, PLL_BYPASS_O);
    cmp("fpo", GPIO_OUT_I, FLAG_PIN_O);
    cmp("fpoe", GPIO_DIR_I, FLAG_PIN_OE_O);
    cmp("fin", FLAG_PIN_I, FLAG_IN_O[3:0]);
    cmp("ado", PP_OUT_I, PPORT_ADDR_DATA_PINS_O);
    cmp("adoe", PP_OE_I, PPORT_ADDR_DATA_PINS_OE_O);
    cmp("ppin", PPORT_ADDR_DATA_PINS_I, PP_IN_O);
    acc(1'b1, 1'b0, 32'h0, 32'h000f_0000);
    acc(1'b0, 1'b0, 32'h0, 32'h0);
    cmp("irq", FLAG_PIN_I[2:0], IRQ_O);
    cmp("tmr", {TIMER_EXPIRED_I, 1'b1}, {FLAG_PIN_O[3], FLAG_PIN_OE_O[3]});
    cmp("fpoe", 32'h8, FLAG_PIN_OE_O);
    // Each pin group in flag mode, then in pulse mode
    for (int g = 0; g < 4; g++)
    begin
      pb = ((g + 2) % 4) * 4;
      acc(1'b1, 1'b0, 32'h0, 32'h0010_0000 | (32'h1 << (22 + g)));
      acc(1'b0, 1'b0, 32'h0, 32'h0);
      eo = PP_OUT_I;
      eoe = PP_OE_I;
      eo[pb+:4] = PPFLAG_OUT_I[4*g+:4];
      eoe[pb+:4] = PPFLAG_DIR_I[4*g+:4];
      cmp("ado", eo, PPORT_ADDR_DATA_PINS_O);
      cmp("adoe", eoe, PPORT_ADDR_DATA_PINS_OE_O);
      cmp("fin", PPORT_ADDR_DATA_PINS_I[pb+:4], FLAG_IN_O[4*g+:4]);
      cmp("irq", FLAG_PIN_I[2:0], IRQ_O);
      cmp("tmr", {TIMER_EXPIRED_I, 1'b1}, {FLAG_PIN_O[3], FLAG_PIN_OE_O[3]});
      acc(1'b1, 1'b0, 32'h0, 32'h1 << (26 + g));
      acc(1'b0, 1'b0, 32'h0, 32'h0);
      eo = PP_OUT_I;
      eo[pb+:4] = PWM_I[pb+:4];
      cmp("ado", eo, PPORT_ADDR_DATA_PINS_O);
      eoe = PP_OE_I;
      eoe[pb+:4] = 4'hf;
      cmp("adoe", eoe, PPORT_ADDR_DATA_PINS_OE_O);
    end
    test_done();
  end
endmodule : spm_top_tb
